// >>> rtl/acmc_ctrl.sv
`timescale 1ns/1ps
// Functional notes
// - One admin card; no local ops without it
// - Unregistered at power-up enters card registration
// - Registration success: green, long beep, verify
// - Registration offered again only after reset
// - Registration mode times out after 15 s
// - Verify: green blink every 2 s, silent
// - One admin swipe enters enrollment
// - Five admin swipes enter deletion
// - Series gaps must stay below 5 s
// - Enrollment allocates new id; double blink, beeps
// - One user per session: one card, ten fingers
// - Three presses or one card; ok/fail indication
// - Reject duplicate or poor-quality enrollment
// - Stay enrolling the same user after attempts
// - Admin swipe ends enrollment to verify
// - Enrollment exits after 20 s idle or full
// - Deletion: red double blink, two short beeps
// - Deletion result indicated; stay in deletion
// - Admin swipe ends deletion to verify
// - Deleting any credential removes whole user
// - Admin card never unlocks; user card or fingerprint does
// - General failure tone selectable: two short beeps
module acmc_ctrl #(
    parameter int                          UNIT_CYC      = acmc_pkg::UNIT_CYC,
    parameter logic [acmc_pkg::PH_W-1:0]   LED_ON_UNITS  = acmc_pkg::LED_ON_DEF,
    parameter logic [acmc_pkg::PH_W-1:0]   LONG_UNITS    = acmc_pkg::LONG_BEEP_DEF,
    parameter logic [acmc_pkg::PH_W-1:0]   SHORT_UNITS   = acmc_pkg::SHORT_BEEP_DEF,
    parameter logic [acmc_pkg::PH_W-1:0]   SECOND_UNITS  = acmc_pkg::SECOND_DEF,
    parameter int                          UID_W         = acmc_pkg::UID_W_DEF
) (
    // Clock and reset
    input  wire logic                    ref_clk_i,
    input  wire logic                    srst_i,
    // Front end events and options
    input  wire acmc_pkg::acmc_event_type ev_i,
    input  wire logic                    fail_tone_sel_i,
    // Indicators
    output logic                         green_led_o,
    output logic                         red_led_o,
    output logic                         buzzer_o,
    // Commands and status
    output acmc_pkg::acmc_cmd_type       cmd_o,
    output logic [UID_W-1:0]             uid_o,
    output acmc_pkg::acmc_mode_type      mode_o,
    output logic                         admin_registered_o
);

    function automatic logic in_win(input logic [acmc_pkg::PH_W-1:0] ph,
                                    input logic [acmc_pkg::PH_W-1:0] start,
                                    input logic [acmc_pkg::PH_W-1:0] len);
        in_win = (ph >= start) && ({1'b0, ph} < {1'b0, start} + {1'b0, len});
    endfunction : in_win

    logic                            unit_tick;
    logic                            sec_tick;
    acmc_pkg::acmc_mode_type         mode_r;
    acmc_pkg::acmc_mode_type         mode_nxt;
    logic                            admin_reg_r;
    logic                            ind_r;
    logic                            ind_ok_r;
    logic [acmc_pkg::PH_W-1:0]       ind_cnt_r;
    logic [acmc_pkg::PH_W-1:0]       phase_r;
    logic [acmc_pkg::SEC_W-1:0]      idle_s_r;
    logic [acmc_pkg::GAP_W-1:0]      gap_r;
    logic [acmc_pkg::SW_W-1:0]       swipes_r;
    logic                            series_r;
    logic [UID_W-1:0]                uid_r;
    logic                            card_cnt_r;
    logic [acmc_pkg::FIN_W-1:0]      fin_cnt_r;
    logic [acmc_pkg::PR_W-1:0]       press_r;

    acmc_tick #(
        .UNIT_CYC (UNIT_CYC)
    ) i_acmc_tick (
        .ref_clk_i   (ref_clk_i),
        .srst_i      (srst_i),
        .unit_tick_o (unit_tick),
        .sec_tick_o  (sec_tick)
    );

    // Event decode
    wire in_reg    = (mode_r == acmc_pkg::MODE_REGISTER);
    wire in_ver    = (mode_r == acmc_pkg::MODE_VERIFY);
    wire in_enr    = (mode_r == acmc_pkg::MODE_ENROLL);
    wire in_del    = (mode_r == acmc_pkg::MODE_DELETE);
    wire ok        = ev_i.result_ok;
    wire ev_admin  = ev_i.admin_card && admin_reg_r;
    wire ev_cred   = ev_i.user_card || ev_i.finger_press;
    wire any_ev    = ev_i.admin_card || ev_cred;

    wire reg_done  = in_reg && ev_i.user_card;
    wire reg_ok    = reg_done && ok && !admin_reg_r;
    wire ver_done  = in_ver && ev_cred;
    wire unlock    = ver_done && ok;
    wire last_pr   = (press_r == acmc_pkg::LAST_PRESS);
    wire enr_card  = in_enr && ev_i.user_card;
    wire enr_fing  = in_enr && ev_i.finger_press && last_pr;
    wire card_ok   = enr_card && ok && !card_cnt_r;
    wire fing_ok   = enr_fing && ok && (fin_cnt_r < acmc_pkg::MAX_FINGERS);
    wire enr_ok    = card_ok || fing_ok;
    wire del_done  = in_del && ev_cred;
    wire del_ok    = del_done && ok;
    wire ind_start = reg_done || ver_done || enr_card || enr_fing || del_done;
    wire ind_res   = reg_ok || unlock || enr_ok || del_ok;

    wire card_full = card_cnt_r || card_ok;
    wire fin_full  = (fin_cnt_r == acmc_pkg::MAX_FINGERS) ||
                     (fing_ok && (fin_cnt_r == acmc_pkg::MAX_FINGERS - 1'b1));
    wire enr_full  = card_full && fin_full;
    wire resolve   = in_ver && series_r && (gap_r == acmc_pkg::GAP_UNITS) && !ev_admin;

    // Mode selection
    always_comb begin
        mode_nxt = mode_r;
        unique case (mode_r)
            acmc_pkg::MODE_REGISTER: begin
                if (reg_ok || (idle_s_r >= acmc_pkg::REG_TIMEOUT && !any_ev)) begin
                    mode_nxt = acmc_pkg::MODE_VERIFY;
                end
            end
            acmc_pkg::MODE_VERIFY: begin
                if (resolve && swipes_r == acmc_pkg::ENROLL_SWIPES) begin
                    mode_nxt = acmc_pkg::MODE_ENROLL;
                end else if (resolve && swipes_r == acmc_pkg::DELETE_SWIPES) begin
                    mode_nxt = acmc_pkg::MODE_DELETE;
                end
            end
            acmc_pkg::MODE_ENROLL: begin
                if (ev_admin || enr_full || (idle_s_r >= acmc_pkg::ENR_TIMEOUT && !any_ev)) begin
                    mode_nxt = acmc_pkg::MODE_VERIFY;
                end
            end
            acmc_pkg::MODE_DELETE: begin
                if (ev_admin) begin
                    mode_nxt = acmc_pkg::MODE_VERIFY;
                end
            end
        endcase
    end

    wire mode_chg  = (mode_nxt != mode_r);
    wire enr_enter = mode_chg && (mode_nxt == acmc_pkg::MODE_ENROLL);

    // Mode, idle timer and admin flag
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            mode_r      <= acmc_pkg::MODE_REGISTER;
            admin_reg_r <= 1'b0;
            idle_s_r    <= '0;
        end else begin
            mode_r      <= mode_nxt;
            admin_reg_r <= admin_reg_r || reg_ok;
            idle_s_r    <= (any_ev || mode_chg) ? '0 :
                           (sec_tick && idle_s_r != acmc_pkg::SEC_SAT) ? idle_s_r + 1'b1 : idle_s_r;
        end
    end

    // Admin swipe series
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            series_r <= 1'b0;
            swipes_r <= '0;
            gap_r    <= '0;
        end else if (in_ver && ev_admin) begin
            series_r <= 1'b1;
            swipes_r <= (swipes_r == acmc_pkg::SWIPE_SAT) ? swipes_r : swipes_r + 1'b1;
            gap_r    <= '0;
        end else if (!in_ver || resolve) begin
            series_r <= 1'b0;
            swipes_r <= '0;
            gap_r    <= '0;
        end else if (series_r && unit_tick) begin
            gap_r    <= gap_r + 1'b1;
        end
    end

    // Enrollment session bookkeeping
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            uid_r      <= '0;
            card_cnt_r <= 1'b0;
            fin_cnt_r  <= '0;
            press_r    <= '0;
        end else if (enr_enter) begin
            uid_r      <= uid_r + 1'b1;
            card_cnt_r <= 1'b0;
            fin_cnt_r  <= '0;
            press_r    <= '0;
        end else begin
            card_cnt_r <= card_cnt_r || card_ok;
            fin_cnt_r  <= fing_ok ? fin_cnt_r + 1'b1 : fin_cnt_r;
            if (in_enr && ev_i.finger_press) begin
                press_r <= last_pr ? '0 : press_r + 1'b1;
            end
        end
    end

    // Pattern period per mode
    wire [acmc_pkg::PH_W-1:0] period = in_ver ? acmc_pkg::PER2_UNITS : acmc_pkg::PER3_UNITS;

    // One-second indication and pattern phase
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            ind_r     <= 1'b0;
            ind_ok_r  <= 1'b0;
            ind_cnt_r <= '0;
            phase_r   <= '0;
        end else begin
            if (ind_start) begin
                ind_r     <= 1'b1;
                ind_ok_r  <= ind_res;
                ind_cnt_r <= '0;
            end else if (ind_r && unit_tick) begin
                ind_r     <= (ind_cnt_r != acmc_pkg::IND_UNITS - 1'b1);
                ind_cnt_r <= ind_cnt_r + 1'b1;
            end
            if (ind_r || ind_start || mode_chg) begin
                phase_r <= '0;
            end else if (unit_tick) begin
                phase_r <= (phase_r == period - 1'b1) ? '0 : phase_r + 1'b1;
            end
        end
    end

    // Pattern decode
    wire blink1  = in_win(phase_r, '0, LED_ON_UNITS);
    wire blink2  = blink1 || in_win(phase_r, SECOND_UNITS, LED_ON_UNITS);
    wire short2  = in_win(phase_r, '0, SHORT_UNITS) || in_win(phase_r, SECOND_UNITS, SHORT_UNITS);
    wire pat_grn = ((in_reg || in_ver) && blink1) || (in_enr && blink2);
    wire pat_red = in_del && blink2;
    wire pat_bz  = (in_reg && in_win(phase_r, '0, LONG_UNITS)) || ((in_enr || in_del) && short2);
    wire ind_two = !ind_ok_r && fail_tone_sel_i;
    wire ind_bz  = ind_two ? (in_win(ind_cnt_r, '0, SHORT_UNITS) ||
                              in_win(ind_cnt_r, SECOND_UNITS, SHORT_UNITS))
                           : in_win(ind_cnt_r, '0, LONG_UNITS);

    // Registered outputs
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            green_led_o        <= 1'b0;
            red_led_o          <= 1'b0;
            buzzer_o           <= 1'b0;
            cmd_o              <= '0;
            uid_o              <= '0;
            mode_o             <= acmc_pkg::MODE_REGISTER;
            admin_registered_o <= 1'b0;
        end else begin
            green_led_o        <= ind_r ? ind_ok_r : pat_grn;
            red_led_o          <= ind_r ? !ind_ok_r : pat_red;
            buzzer_o           <= ind_r ? ind_bz : pat_bz;
            cmd_o.admin_store  <= reg_ok;
            cmd_o.enroll_card  <= card_ok;
            cmd_o.enroll_finger <= fing_ok;
            cmd_o.delete_user  <= del_ok;
            cmd_o.unlock       <= unlock;
            uid_o              <= uid_r;
            mode_o             <= mode_r;
            admin_registered_o <= admin_reg_r;
        end
    end

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (srst_i);

    a_admin_no_unlock: assert property (ev_i.admin_card && !ev_cred |=> !cmd_o.unlock)
        else $error("Admin card caused unlock");
    a_reg_success: assert property (in_reg && reg_ok |=>
        (mode_r == acmc_pkg::MODE_VERIFY && cmd_o.admin_store) ##1 admin_registered_o)
        else $error("Registration did not reach verify");
    a_reg_timeout: assert property (in_reg && idle_s_r == acmc_pkg::REG_TIMEOUT && !any_ev
        |=> mode_r == acmc_pkg::MODE_VERIFY)
        else $error("Registration timeout missed");
    a_reg_once: assert property (!in_reg |=> !in_reg)
        else $error("Registration mode re-entered");
    a_local_needs_admin: assert property (!admin_reg_r |-> !in_enr && !in_del)
        else $error("Local op without admin card");
    a_enroll_quit: assert property (in_enr && ev_admin |=> in_ver)
        else $error("Enrollment not ended by admin card");
    a_delete_quit: assert property (in_del && ev_admin |=> in_ver)
        else $error("Deletion not ended by admin card");
    a_new_uid: assert property (!in_enr ##1 in_enr |-> uid_r == $past(uid_r) + 1'b1)
        else $error("No new user id on enrollment");
    a_finger_cap: assert property (fin_cnt_r <= acmc_pkg::MAX_FINGERS)
        else $error("Finger count above limit");
    a_verify_quiet: assert property (in_ver && !ind_r |=> !buzzer_o && !red_led_o)
        else $error("Verify mode not silent");
    a_ind_ok_green: assert property (ind_start && ind_res ##1 !ind_start |=> green_led_o && !red_led_o)
        else $error("Success indication not green");
    a_delete_stays: assert property (in_del && del_done && !ev_admin |=> in_del)
        else $error("Deletion mode left after attempt");
    a_enroll_idle: assert property (in_enr && idle_s_r >= acmc_pkg::ENR_TIMEOUT && !any_ev |=> in_ver)
        else $error("Enrollment idle timeout missed");

    c_enroll_entry: cover property (in_ver ##1 in_enr);
    c_delete_entry: cover property (in_ver ##1 in_del);
    c_reg_timeout:  cover property (in_reg && !admin_reg_r ##1 in_ver);
    c_enroll_full:  cover property (in_enr && enr_full);

endmodule : acmc_ctrl

// >>> rtl/acmc_pkg.sv
package acmc_pkg;

    // Clock and time base
    localparam int CLK_PERIOD_NS  = 40;
    localparam int UNIT_NS        = 100_000_000;
    localparam int UNIT_CYC       = (UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int UNITS_PER_SEC  = 10;

    // Widths
    localparam int PH_W   = 5;
    localparam int SEC_W  = 5;
    localparam int GAP_W  = 6;
    localparam int SW_W   = 3;
    localparam int FIN_W  = 4;
    localparam int PR_W   = 2;

    // Timing in seconds and units
    localparam int REG_TIMEOUT_S = 15;
    localparam int ENR_TIMEOUT_S = 20;
    localparam int GAP_S         = 5;
    localparam logic [SEC_W-1:0] REG_TIMEOUT = SEC_W'(REG_TIMEOUT_S);
    localparam logic [SEC_W-1:0] ENR_TIMEOUT = SEC_W'(ENR_TIMEOUT_S);
    localparam logic [GAP_W-1:0] GAP_UNITS   = GAP_W'(GAP_S * UNITS_PER_SEC);
    localparam logic [PH_W-1:0]  IND_UNITS   = PH_W'(UNITS_PER_SEC);
    localparam logic [PH_W-1:0]  PER2_UNITS  = PH_W'(2 * UNITS_PER_SEC);
    localparam logic [PH_W-1:0]  PER3_UNITS  = PH_W'(3 * UNITS_PER_SEC);

    // Pattern defaults, in units of 100 ms
    localparam logic [PH_W-1:0] LED_ON_DEF     = PH_W'(2);
    localparam logic [PH_W-1:0] LONG_BEEP_DEF  = PH_W'(5);
    localparam logic [PH_W-1:0] SHORT_BEEP_DEF = PH_W'(1);
    localparam logic [PH_W-1:0] SECOND_DEF     = PH_W'(4);

    // Counts
    localparam logic [FIN_W-1:0] MAX_FINGERS    = FIN_W'(10);
    localparam logic [PR_W-1:0]  LAST_PRESS     = PR_W'(2);
    localparam logic [SW_W-1:0]  ENROLL_SWIPES  = SW_W'(1);
    localparam logic [SW_W-1:0]  DELETE_SWIPES  = SW_W'(5);
    localparam logic [SW_W-1:0]  SWIPE_SAT      = '1;
    localparam logic [SEC_W-1:0] SEC_SAT        = '1;
    localparam int               UID_W_DEF      = 12;

    typedef enum logic [1:0] {
        MODE_REGISTER,
        MODE_VERIFY,
        MODE_ENROLL,
        MODE_DELETE
    } acmc_mode_type;

    // One-cycle credential events from the reader and sensor front end
    typedef struct packed {
        logic admin_card;
        logic user_card;
        logic finger_press;
        logic result_ok;
    } acmc_event_type;

    // One-cycle commands back to storage and door logic
    typedef struct packed {
        logic admin_store;
        logic enroll_card;
        logic enroll_finger;
        logic delete_user;
        logic unlock;
    } acmc_cmd_type;

endpackage : acmc_pkg

// >>> rtl/acmc_tick.sv
`timescale 1ns/1ps
module acmc_tick #(
    parameter int UNIT_CYC = acmc_pkg::UNIT_CYC
) (
    // Clock and reset
    input  wire logic ref_clk_i,
    input  wire logic srst_i,
    // Ticks
    output logic      unit_tick_o,
    output logic      sec_tick_o
);
    localparam int CW = $clog2(UNIT_CYC);
    localparam logic [CW-1:0] CYC_LAST = CW'(UNIT_CYC - 1);
    localparam logic [3:0]    SUB_LAST = 4'(acmc_pkg::UNITS_PER_SEC - 1);

    logic [CW-1:0] cyc_r;
    logic [3:0]    sub_r;
    wire           cyc_wrap = (cyc_r == CYC_LAST);
    wire           sub_wrap = cyc_wrap && (sub_r == SUB_LAST);

    // Unit and one-second timebase
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            cyc_r       <= '0;
            sub_r       <= '0;
            unit_tick_o <= 1'b0;
            sec_tick_o  <= 1'b0;
        end else begin
            cyc_r       <= cyc_wrap ? '0 : cyc_r + 1'b1;
            sub_r       <= sub_wrap ? '0 : (cyc_wrap ? sub_r + 1'b1 : sub_r);
            unit_tick_o <= cyc_wrap;
            sec_tick_o  <= sub_wrap;
        end
    end

endmodule : acmc_tick

// >>> verif/acmc_fe_model.sv
`timescale 1ns/1ps
module acmc_fe_model #(
    parameter int UNIT_CYC = 4
) (
    // Clock
    input  wire logic                 ref_clk_i,
    // Events to the controller
    output acmc_pkg::acmc_event_type  ev_o
);
    initial ev_o = '0;

    // One-cycle event; result line shows the inverse once released
    task automatic pulse(input logic adm, input logic crd, input logic fin, input logic ok);
        @(posedge ref_clk_i);
        #1;
        ev_o = '{admin_card: adm, user_card: crd, finger_press: fin, result_ok: ok};
        @(posedge ref_clk_i);
        #1;
        ev_o = '{admin_card: 1'b0, user_card: 1'b0, finger_press: 1'b0, result_ok: ~ok};
    endtask : pulse

    task automatic present_admin;
        pulse(1'b1, 1'b0, 1'b0, 1'b1);
    endtask : present_admin

    task automatic present_card(input logic ok);
        pulse(1'b0, 1'b1, 1'b0, ok);
    endtask : present_card

    task automatic press_finger(input logic ok);
        pulse(1'b0, 1'b0, 1'b1, ok);
    endtask : press_finger

    // Three presses of one finger, last carries the outcome
    task automatic enroll_finger(input logic ok);
        press_finger(1'b1);
        press_finger(1'b1);
        press_finger(ok);
    endtask : enroll_finger

    // Swipes one second apart, inside the series gap
    task automatic admin_series(input int n);
        for (int i = 0; i < n; i++) begin
            present_admin();
            repeat (10 * UNIT_CYC) @(posedge ref_clk_i);
        end
    endtask : admin_series
endmodule : acmc_fe_model

// >>> verif/test_acmc_ctrl.sv
`timescale 1ns/1ps
module test_acmc_ctrl;
    localparam int U = 4;
    logic                     ref_clk_i       = 1'b0;
    logic                     srst_i          = 1'b1;
    logic                     fail_tone_sel_i = 1'b0;
    acmc_pkg::acmc_event_type ev;
    logic                     green_led_o;
    logic                     red_led_o;
    logic                     buzzer_o;
    acmc_pkg::acmc_cmd_type   cmd_o;
    logic [11:0]              uid_o;
    logic [11:0]              uid_a;
    logic                     ok_v;
    int                       n_v;
    acmc_pkg::acmc_mode_type  mode_o;
    logic                     admin_registered_o;
    int                       fail_count = 0;
    int                       checks     = 0;
    int                       n_store, n_ecard, n_efing, n_del, n_unl;
    int                       rg, rr, rb, hg, hr, hb;

    acmc_fe_model #(.UNIT_CYC(U)) i_acmc_fe_model (.ref_clk_i(ref_clk_i), .ev_o(ev));

    acmc_ctrl #(.UNIT_CYC(U)) i_acmc_ctrl (
        .ref_clk_i(ref_clk_i), .srst_i(srst_i), .ev_i(ev), .fail_tone_sel_i(fail_tone_sel_i),
        .green_led_o(green_led_o), .red_led_o(red_led_o), .buzzer_o(buzzer_o), .cmd_o(cmd_o),
        .uid_o(uid_o), .mode_o(mode_o), .admin_registered_o(admin_registered_o)
    );

    always #20 ref_clk_i = ~ref_clk_i;

    // Command pulse counters
    always @(posedge ref_clk_i) begin
        if (cmd_o.admin_store === 1'b1) n_store++;
        if (cmd_o.enroll_card === 1'b1) n_ecard++;
        if (cmd_o.enroll_finger === 1'b1) n_efing++;
        if (cmd_o.delete_user === 1'b1) n_del++;
        if (cmd_o.unlock === 1'b1) n_unl++;
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value %s expected %0h seen %0h", name, exp, seen);
        end
    endtask : check

    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : finish_test

    task automatic wait_units(input int n);
        repeat (n * U) @(posedge ref_clk_i);
        #1;
    endtask : wait_units

    task automatic clr;
        n_store = 0;
        n_ecard = 0;
        n_efing = 0;
        n_del = 0;
        n_unl = 0;
    endtask : clr

    task automatic wait_mode(input acmc_pkg::acmc_mode_type m, input int units);
        int k;
        k = 0;
        while (mode_o !== m && k < units * U) begin
            @(posedge ref_clk_i);
            #1;
            k++;
        end
        check("mode", 32'(mode_o), 32'(m));
    endtask : wait_mode

    // Rising edges and lit cycles of the indicators over n units
    task automatic measure(input int n);
        logic pg, pr, pb;
        rg = 0;
        rr = 0;
        rb = 0;
        hg = 0;
        hr = 0;
        hb = 0;
        pg = green_led_o;
        pr = red_led_o;
        pb = buzzer_o;
        repeat (n * U) begin
            @(posedge ref_clk_i);
            #1;
            rg += (green_led_o === 1'b1 && pg !== 1'b1);
            rr += (red_led_o === 1'b1 && pr !== 1'b1);
            rb += (buzzer_o === 1'b1 && pb !== 1'b1);
            hg += (green_led_o === 1'b1);
            hr += (red_led_o === 1'b1);
            hb += (buzzer_o === 1'b1);
            pg = green_led_o;
            pr = red_led_o;
            pb = buzzer_o;
        end
    endtask : measure

    // Steady one-second indication, other colour dark
    task automatic ind(input logic grn);
        measure(9);
        check("lit", (grn ? hg : hr) >= 8 * U, 1);
        check("dark", grn ? hr : hg, 0);
    endtask : ind

    task automatic do_reset;
        srst_i = 1'b1;
        repeat (16) @(posedge ref_clk_i);
        #1;
        srst_i = 1'b0;
        clr();
    endtask : do_reset

    task automatic t_reg_timeout;
        do_reset();
        check("mode", 32'(mode_o), 32'(acmc_pkg::MODE_REGISTER));
        wait_units(130);
        check("mode", 32'(mode_o), 32'(acmc_pkg::MODE_REGISTER));
        wait_mode(acmc_pkg::MODE_VERIFY, 40);
        ok_v = 1'b1;
        i_acmc_fe_model.present_card(ok_v);
        i_acmc_fe_model.present_admin();
        wait_units(60);
        check("store", n_store, 0);
        check("uid", 32'(uid_o), 0);
        check("reg", 32'(admin_registered_o), 0);
        check("mode", 32'(mode_o), 32'(acmc_pkg::MODE_VERIFY));
        $display("test reg_timeout done");
    endtask : t_reg_timeout

    task automatic t_register;
        do_reset();
        wait_units(5);
        measure(30);
        check("g_rise", rg, 1);
        check("b_rise", rb, 1);
        check("b_len", hb, 5 * U);
        i_acmc_fe_model.present_admin();
        wait_units(2);
        check("mode", 32'(mode_o), 32'(acmc_pkg::MODE_REGISTER));
        ok_v = 1'b1;
        i_acmc_fe_model.present_card(ok_v);
        measure(9);
        check("g_len", hg >= 8 * U, 1);
        check("b_rise", rb, 1);
        check("store", n_store, 1);
        check("reg", 32'(admin_registered_o), 1);
        wait_mode(acmc_pkg::MODE_VERIFY, 10);
        $display("test register done");
    endtask : t_register

    task automatic t_verify;
        wait_units(15);
        measure(20);
        check("g_rise", rg, 1);
        check("g_len", hg, 2 * U);
        check("b_rise", rb, 0);
        ok_v = 1'b1;
        i_acmc_fe_model.present_card(ok_v);
        wait_units(15);
        check("unlock", n_unl, 1);
        fail_tone_sel_i = 1'b1;
        ok_v = 1'b0;
        i_acmc_fe_model.present_card(ok_v);
        ind(1'b0);
        check("b_rise", rb, 2);
        wait_units(15);
        fail_tone_sel_i = 1'b0;
        i_acmc_fe_model.present_card(ok_v);
        ind(1'b0);
        check("b_rise", rb, 1);
        wait_units(15);
        $display("test verify done");
    endtask : t_verify

    task automatic t_enroll;
        clr();
        i_acmc_fe_model.present_admin();
        wait_units(30);
        check("mode", 32'(mode_o), 32'(acmc_pkg::MODE_VERIFY));
        check("unlock", n_unl, 0);
        wait_mode(acmc_pkg::MODE_ENROLL, 30);
        uid_a = uid_o;
        check("uid", 32'(uid_o), 1);
        measure(30);
        check("g_rise", rg, 2);
        check("b_rise", rb, 2);
        check("b_len", hb, 2 * U);
        ok_v = 1'b1;
        i_acmc_fe_model.enroll_finger(ok_v);
        ind(1'b1);
        ok_v = 1'b0;
        i_acmc_fe_model.enroll_finger(ok_v);
        ind(1'b0);
        check("finger", n_efing, 1);
        ok_v = 1'b1;
        i_acmc_fe_model.present_card(ok_v);
        ind(1'b1);
        i_acmc_fe_model.present_card(ok_v);
        ind(1'b0);
        check("card", n_ecard, 1);
        check("mode", 32'(mode_o), 32'(acmc_pkg::MODE_ENROLL));
        check("uid", 32'(uid_o), 32'(uid_a));
        i_acmc_fe_model.present_admin();
        wait_mode(acmc_pkg::MODE_VERIFY, 60);
        $display("test enroll done");
    endtask : t_enroll

    task automatic t_enroll_full;
        i_acmc_fe_model.present_admin();
        wait_mode(acmc_pkg::MODE_ENROLL, 60);
        check("uid", 32'(uid_o), 32'(uid_a + 12'h0001));
        wait_units(180);
        check("mode", 32'(mode_o), 32'(acmc_pkg::MODE_ENROLL));
        wait_mode(acmc_pkg::MODE_VERIFY, 40);
        i_acmc_fe_model.present_admin();
        wait_mode(acmc_pkg::MODE_ENROLL, 60);
        clr();
        ok_v = 1'b1;
        i_acmc_fe_model.present_card(ok_v);
        repeat (10) i_acmc_fe_model.enroll_finger(ok_v);
        wait_mode(acmc_pkg::MODE_VERIFY, 3);
        check("finger", n_efing, 10);
        check("card", n_ecard, 1);
        $display("test enroll_full done");
    endtask : t_enroll_full

    task automatic t_delete;
        wait_units(15);
        n_v = 3;
        i_acmc_fe_model.admin_series(n_v);
        wait_units(60);
        check("mode", 32'(mode_o), 32'(acmc_pkg::MODE_VERIFY));
        n_v = 5;
        i_acmc_fe_model.admin_series(n_v);
        wait_mode(acmc_pkg::MODE_DELETE, 60);
        measure(30);
        check("r_rise", rr, 2);
        check("g_rise", rg, 0);
        check("b_len", hb, 2 * U);
        clr();
        ok_v = 1'b1;
        i_acmc_fe_model.press_finger(ok_v);
        ind(1'b1);
        check("delete", n_del, 1);
        ok_v = 1'b0;
        i_acmc_fe_model.present_card(ok_v);
        ind(1'b0);
        check("delete", n_del, 1);
        check("mode", 32'(mode_o), 32'(acmc_pkg::MODE_DELETE));
        i_acmc_fe_model.present_admin();
        wait_mode(acmc_pkg::MODE_VERIFY, 60);
        $display("test delete done");
    endtask : t_delete

    initial begin
        #(20000 * 40);
        fail_count++;
        finish_test();
    end

    initial begin
        t_reg_timeout();
        t_register();
        t_verify();
        t_enroll();
        t_enroll_full();
        t_delete();
        finish_test();
    end
endmodule : test_acmc_ctrl
